/* ctf_pkg.sv */
package ctf_pkg;

    // Datapath sizes
    localparam int TAPS   = 32;
    localparam int DATA_W = 16;
    localparam int COEF_W = 16;
    localparam int ACC_W  = 36;
    localparam int OUT_W  = 24;
    localparam int ADDR_W = 8;
    localparam int BUS_W  = 32;

    // Register word addresses
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STAT = 8'h01;
    localparam logic [ADDR_W-1:0] REG_DIN  = 8'h02;
    localparam logic [ADDR_W-1:0] REG_DOUT = 8'h03;
    localparam logic [ADDR_W-1:0] REG_COEF = 8'h20;

    // Control field positions
    localparam int CTRL_SWAP  = 0;
    localparam int CTRL_CONT  = 1;
    localparam int CTRL_CW    = 2;
    localparam int CTRL_SH    = 4;
    localparam int CTRL_MEMIO = 6;

    // Status field positions
    localparam int STAT_BANK  = 0;
    localparam int STAT_BUSY  = 1;
    localparam int STAT_OUTV  = 2;
    localparam int STAT_INRDY = 3;

    // Values after reset: 16-bit coefficients, window at bit 7
    localparam logic [1:0] CW_RST = 2'h3;
    localparam logic [1:0] SH_RST = 2'h0;

    // Lowest bit of the output window per shift code
    localparam int SH_LSB0 = 7;
    localparam int SH_LSB1 = 11;
    localparam int SH_LSB2 = 15;
    localparam int SH_LSB3 = 20;

    // Clock and host access timing
    localparam int CLK_NS      = 40;
    localparam int MEM_CYC_NS  = 100;
    localparam int MEM_CYC_CLK = (MEM_CYC_NS / CLK_NS < 1) ? 1
                                 : MEM_CYC_NS / CLK_NS;

    // One host access in one cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BUS_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } ctf_bus_t;

endpackage

/* ctf_buf.sv */
`timescale 1ns/1ns

module ctf_buf #(
    parameter int W = 24
) (
    input  wire logic         clock_i,     // System clock
    input  wire logic         reset_i,     // Synchronous reset
    input  wire logic         in_valid_i,  // Word offered
    input  wire logic [W-1:0] in_data_i,   // Word in
    output logic              in_ready_o,  // Room for a word
    output logic              out_valid_o, // Word available
    output logic [W-1:0]      out_data_o,  // Oldest word
    input  wire logic         out_ready_i  // Drain accepts
);

    typedef struct packed {
        logic [1:0][W-1:0] data;
        logic [1:0]        cnt;
    } ctf_buf_st_t;

    ctf_buf_st_t s_r;
    ctf_buf_st_t s_nxt;
    logic        push;
    logic        pop;

    ////////////////////////////////////////////////////////////////////
    // Handshakes: full at two words, empty at none
    assign in_ready_o  = (s_r.cnt != 2'h2);
    assign out_valid_o = (s_r.cnt != 2'h0);
    assign out_data_o  = s_r.data[0];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    ////////////////////////////////////////////////////////////////////
    // Next state: pop shifts entry 1 down, push lands behind the rest
    always_comb begin
        s_nxt = s_r;
        if (pop) begin
            s_nxt.data[0] = s_r.data[1];
            s_nxt.cnt     = s_r.cnt - 2'h1;
        end
        if (push) begin
            s_nxt.data[s_nxt.cnt[0]] = in_data_i;
            s_nxt.cnt                = s_nxt.cnt + 2'h1;
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // ctf_buf

/* ctf_filter.sv */
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns

// Operation
// RL1: Thirty-two multipliers each feed one stage of a 32-stage add chain.
// RL2: Partial sums move down the chain so the output is the tapped sum.
// RL3: Every input sample is a 16-bit signed word.
// RL4: Coefficient length is selectable as 4, 8, 12 or 16 bits.
// RL5: The cycles spent per sample scale with the coefficient length.
// RL6: Two coefficient banks exist; one is active, the other host-visible.
// RL7: Host accesses complete in a single clock, within 100 ns.
// RL8: A control write swaps which bank feeds the multipliers.
// RL9: Continuous mode alternates the banks after every computation.
// RL10: Samples and results go via the data ports or the register port.
// RL11: Products and chain sums keep full precision to 36 bits.
// RL12: A 24-bit window starting at bit 7, 11, 15 or 20 is selected.
// RL13: A 32-stage 24-bit cascade shift register and adder are built in.
// RL14: Each device output is wired to the next device cascade input.
// RL15: Operating settings live in host-accessible control registers.
// RL16: The delayed cascade input is added to the local rounded result.
// RL17: Rounding adds half an output LSB before dropping lower bits.
module ctf_filter
    import ctf_pkg::*;
(
    input  wire logic              clock_i,     // System clock
    input  wire logic              reset_i,     // Synchronous reset
    input  wire ctf_bus_t          bus_i,       // Host access request
    output logic [BUS_W-1:0]       rd_data_o,   // Read data, next cycle
    input  wire logic [DATA_W-1:0] smp_data_i,  // Sample port data
    input  wire logic              smp_valid_i, // Sample offered
    output logic                   smp_ready_o, // Sample taken
    input  wire logic [OUT_W-1:0]  casc_i,      // From previous device
    output logic [OUT_W-1:0]       res_data_o,  // Result port data
    output logic                   res_valid_o, // Result available
    input  wire logic              res_ready_i  // Result accepted
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALC = 2'b01
    } ctf_state_t;

    typedef struct packed {
        logic [1:0][TAPS-1:0][COEF_W-1:0] coef;
        logic [TAPS-1:0][ACC_W-1:0]       chain;
        logic [TAPS-1:0][OUT_W-1:0]       casc;
        logic [DATA_W-1:0]                smp;
        logic                             din_v;
        logic                             bank;
        logic                             cont;
        logic [1:0]                       cw;
        logic [1:0]                       sh;
        logic                             memio;
        logic [1:0]                       cnt;
        ctf_state_t                       st;
        logic [BUS_W-1:0]                 rdata;
    } ctf_st_t;

    ctf_st_t                    s_r;
    ctf_st_t                    s_nxt;
    logic [TAPS-1:0][ACC_W-1:0] prod;
    logic [ACC_W-1:0]           full;
    logic [OUT_W-1:0]           local_res;
    logic [OUT_W-1:0]           out_word;
    logic                       push;
    logic                       buf_in_ready;
    logic                       buf_out_valid;
    logic [OUT_W-1:0]           buf_out_data;
    logic                       buf_out_ready;
    logic                       coef_hit;
    logic [4:0]                 coef_idx;
    logic                       start;
    logic                       dout_pop;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Sign-extend a coefficient from its configured length
    function automatic logic signed [COEF_W-1:0] coef_val(
        input logic [COEF_W-1:0] c,
        input logic [1:0]        cw
    );
        logic [3:0] sa;
        sa = 4'(4'hC - {cw, 2'h0});
        coef_val = $signed(c << sa) >>> sa; // see RL4
    endfunction

    // Full-width signed product; operands widened first so no bit is lost
    function automatic logic [ACC_W-1:0] mul_full(
        input logic signed [DATA_W-1:0] x,
        input logic signed [COEF_W-1:0] c
    );
        logic signed [ACC_W-1:0] xe;
        logic signed [ACC_W-1:0] ce;
        xe       = x;
        ce       = c;
        mul_full = xe * ce; // see RL11
    endfunction

    // Window low bit for a shift code
    function automatic int win_lsb(input logic [1:0] sh);
        case (sh)
            2'h0:    win_lsb = SH_LSB0;
            2'h1:    win_lsb = SH_LSB1;
            2'h2:    win_lsb = SH_LSB2;
            default: win_lsb = SH_LSB3;
        endcase
    endfunction

    // Round and select the 24-bit output window
    function automatic logic [OUT_W-1:0] round_win(
        input logic [ACC_W-1:0] v,
        input logic [1:0]       sh
    );
        logic signed [ACC_W:0] ext;
        logic signed [ACC_W:0] half;
        int                    l;
        l    = win_lsb(sh);
        ext  = $signed({v[ACC_W-1], v});
        half = (ACC_W+1)'(1) <<< (l - 1);
        ext  = (ext + half) >>> l; // see RL17
        round_win = ext[OUT_W-1:0]; // see RL12
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Multiplier array, one per chain stage, at full width
    always_comb begin
        for (int k = 0; k < TAPS; k++) begin
            prod[k] = mul_full(s_r.smp,
                               coef_val(s_r.coef[s_r.bank][k],
                                        s_r.cw)); // see RL1
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output arithmetic: untruncated chain head, window, cascade sum
    assign full      = prod[0] + s_r.chain[1]; // see RL11
    assign local_res = round_win(full, s_r.sh);
    assign out_word  = local_res + s_r.casc[TAPS-1]; // see RL16

    // A result is produced on the last cycle of a computation
    assign push = (s_r.st == ST_CALC) && (s_r.cnt == 2'h0);

    ////////////////////////////////////////////////////////////////////
    // Host decode
    assign coef_hit = (bus_i.addr[ADDR_W-1:5] == REG_COEF[ADDR_W-1:5]);
    assign coef_idx = bus_i.addr[4:0];
    assign dout_pop = bus_i.rd && (bus_i.addr == REG_DOUT) && s_r.memio;

    // Result drain: port handshake or a read of the result register
    assign buf_out_ready = s_r.memio ? dout_pop : res_ready_i; // see RL10
    assign res_valid_o   = buf_out_valid && !s_r.memio;
    assign res_data_o    = buf_out_data;
    assign rd_data_o     = s_r.rdata; // see RL7

    // Sample intake only while idle with room for the result
    assign smp_ready_o = (s_r.st == ST_IDLE) && !s_r.memio && buf_in_ready;
    assign start = (s_r.st == ST_IDLE) && buf_in_ready
                   && (s_r.memio ? s_r.din_v : smp_valid_i); // see RL10

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_nxt = s_r;

        // Read data for a read strobe, zero otherwise
        s_nxt.rdata = '0;
        if (bus_i.rd) begin
            if (coef_hit) begin
                s_nxt.rdata = BUS_W'(s_r.coef[!s_r.bank][coef_idx]); // see RL6
            end else begin
                case (bus_i.addr)
                    REG_CTRL: begin
                        s_nxt.rdata[CTRL_CONT]       = s_r.cont;
                        s_nxt.rdata[CTRL_CW +: 2]    = s_r.cw;
                        s_nxt.rdata[CTRL_SH +: 2]    = s_r.sh;
                        s_nxt.rdata[CTRL_MEMIO]      = s_r.memio;
                    end
                    REG_STAT: begin
                        s_nxt.rdata[STAT_BANK]  = s_r.bank;
                        s_nxt.rdata[STAT_BUSY]  = (s_r.st != ST_IDLE);
                        s_nxt.rdata[STAT_OUTV]  = buf_out_valid;
                        s_nxt.rdata[STAT_INRDY] = !s_r.din_v;
                    end
                    REG_DIN: begin
                        s_nxt.rdata = BUS_W'(s_r.smp);
                    end
                    REG_DOUT: begin
                        s_nxt.rdata = BUS_W'(buf_out_data);
                    end
                    default: begin
                        s_nxt.rdata = '0;
                    end
                endcase
            end
        end

        // Host writes: inactive bank, control settings and input sample
        if (bus_i.wr) begin
            if (coef_hit) begin
                s_nxt.coef[!s_r.bank][coef_idx] =
                    bus_i.wdata[COEF_W-1:0]; // see RL6
            end else begin
                case (bus_i.addr)
                    REG_CTRL: begin
                        s_nxt.cont  = bus_i.wdata[CTRL_CONT]; // see RL15
                        s_nxt.cw    = bus_i.wdata[CTRL_CW +: 2];
                        s_nxt.sh    = bus_i.wdata[CTRL_SH +: 2];
                        s_nxt.memio = bus_i.wdata[CTRL_MEMIO];
                    end
                    REG_DIN: begin
                        s_nxt.smp   = bus_i.wdata[DATA_W-1:0]; // see RL3
                        s_nxt.din_v = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Sequencer
        case (s_r.st)
            ST_IDLE: begin
                if (start) begin
                    if (!s_r.memio) begin
                        s_nxt.smp = smp_data_i; // see RL3
                    end
                    s_nxt.din_v = 1'b0;
                    s_nxt.cnt   = s_r.cw; // see RL5
                    s_nxt.casc  = {s_r.casc[TAPS-2:0], casc_i}; // see RL13
                    s_nxt.st    = ST_CALC;
                end
            end
            ST_CALC: begin
                if (s_r.cnt == 2'h0) begin
                    // Advance the chain: stage k takes stage k+1 plus tap k
                    for (int k = 0; k < TAPS - 1; k++) begin
                        s_nxt.chain[k] = prod[k] + s_r.chain[k+1]; // see RL2
                    end
                    s_nxt.chain[TAPS-1] = prod[TAPS-1];
                    s_nxt.st = ST_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 2'h1;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // Bank exchange by command and in continuous mode
        s_nxt.bank = s_r.bank
                     ^ (bus_i.wr && !coef_hit && (bus_i.addr == REG_CTRL)
                        && bus_i.wdata[CTRL_SWAP]) // see RL8
                     ^ (push && s_r.cont); // see RL9
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s_r    <= '0;
            s_r.cw <= CW_RST;
            s_r.sh <= SH_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Two-word result buffer so a stalled receiver loses nothing
    ctf_buf #(
        .W (OUT_W)
    ) u_buf (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .in_valid_i  (push),
        .in_data_i   (out_word),
        .in_ready_o  (buf_in_ready),
        .out_valid_o (buf_out_valid),
        .out_data_o  (buf_out_data),
        .out_ready_i (buf_out_ready)
    );

endmodule // ctf_filter

/* ctf_filter_properties.sv */
`timescale 1ns/1ns
module ctf_filter_properties
    import ctf_pkg::*;
(
    input wire logic              clock_i,     // System clock
    input wire logic              reset_i,     // Synchronous reset
    input wire ctf_bus_t          bus_i,       // Host request
    input wire logic [BUS_W-1:0]  rd_data_o,   // Read data
    input wire logic [DATA_W-1:0] smp_data_i,  // Sample data
    input wire logic              smp_valid_i, // Sample offered
    input wire logic              smp_ready_o, // Sample taken
    input wire logic [OUT_W-1:0]  casc_i,      // Cascade input
    input wire logic [OUT_W-1:0]  res_data_o,  // Result data
    input wire logic              res_valid_o, // Result available
    input wire logic              res_ready_i  // Result accepted
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic [6:0] ctl_r;
    logic       take;
    assign take = smp_valid_i && smp_ready_o;
    // Mirror of the control fields last written by the host
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ctl_r <= {1'b0, SH_RST, CW_RST, 2'b00};
        end else if (bus_i.wr && bus_i.addr == REG_CTRL) begin
            ctl_r <= {bus_i.wdata[6:1], 1'b0};
        end
    end
    // Sample accepted into an empty buffer, shortest and longest width
    sequence s_take_fast;
        take && !res_valid_o && ctl_r[3:2] == 2'h0;
    endsequence
    sequence s_take_slow;
        take && !res_valid_o && ctl_r[3:2] == 2'h3;
    endsequence
    sequence s_wait_slow;
        !res_valid_o [*4] ##1 res_valid_o;
    endsequence
    a_reset_idle: assert property (disable iff (1'b0) reset_i |=>
        !res_valid_o && smp_ready_o && rd_data_o == '0)
        else $error("outputs not idle after reset");
    a_read_idle: assert property (!bus_i.rd |=> rd_data_o == '0)
        else $error("read data outside the answer cycle");
    a_ctrl_back: assert property (bus_i.rd && bus_i.addr == REG_CTRL
        |=> rd_data_o == {25'h0, ctl_r}) else $error("control readback");
    a_hole_zero: assert property (bus_i.rd
        && bus_i.addr inside {[8'h04:8'h1F]} |=> rd_data_o == '0)
        else $error("unmapped read not zero");
    a_busy_fast: assert property (take && ctl_r[3:2] == 2'h0
        |=> !smp_ready_o) else $error("short width busy span");
    a_busy_slow: assert property (take && ctl_r[3:2] == 2'h3
        |=> !smp_ready_o [*4]) else $error("long width busy span");
    a_lat_fast: assert property (s_take_fast
        |=> !res_valid_o ##1 res_valid_o) else $error("short latency");
    a_lat_slow: assert property (s_take_slow |=> s_wait_slow)
        else $error("long latency");
    a_res_hold: assert property (res_valid_o && !res_ready_i
        |=> res_valid_o && $stable(res_data_o)) else $error("result lost");
    a_mem_quiet: assert property (ctl_r[6]
        |-> !res_valid_o && !smp_ready_o) else $error("ports live in memio");
endmodule // ctf_filter_properties

bind ctf_filter ctf_filter_properties u_ctf_filter_properties (
    .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus_i),
    .rd_data_o(rd_data_o), .smp_data_i(smp_data_i),
    .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o),
    .casc_i(casc_i), .res_data_o(res_data_o),
    .res_valid_o(res_valid_o), .res_ready_i(res_ready_i)
);

/* ctf_peer.sv */
`timescale 1ns/1ns
module ctf_peer (
    input  wire logic   clock_i, // System clock
    input  wire logic   reset_i, // Synchronous reset
    input  wire logic   take_i,  // Sample taken by the filter
    input  wire logic   hold_i,  // Long drain stall
    output logic [23:0] casc_o,  // Previous device output
    output logic        ready_o  // Drain accepts
);
    logic [1:0] cnt_r;
    // Upstream result moves once per sample; drain stalls one cycle in four
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cnt_r  <= 2'h0;
            casc_o <= 24'h000000;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            if (take_i) begin
                casc_o <= casc_o + 24'h9E377B;
            end
        end
    end
    assign ready_o = !hold_i && cnt_r != 2'h3;
endmodule // ctf_peer

/* ctf_filter_test.sv */
`timescale 1ns/1ns
module ctf_filter_test
    import ctf_pkg::*;
;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    ctf_bus_t    bus = '0;
    logic [15:0] smp_data = '0;
    logic        smp_valid = 1'b0;
    logic        hold = 1'b0;
    logic [31:0] rd_data;
    logic [23:0] casc, res_data;
    logic        smp_ready, res_valid, res_ready;
    int          fail_count = 0, checks = 0;
    logic [31:0] rng = 32'h02477F48;
    logic [15:0] coef[2][32];
    longint      ch[33];
    logic [23:0] cq[$], xq[$];
    logic [31:0] rq[$];
    logic        mb = 1'b0, cont = 1'b0, rd_prev = 1'b0;
    logic [1:0]  cwm = CW_RST, shm = SH_RST;

    always #(CLK_NS / 2) clock_i = ~clock_i;

    ctf_filter u_ctf_filter (.clock_i(clock_i), .reset_i(reset_i),
        .bus_i(bus), .rd_data_o(rd_data), .smp_data_i(smp_data),
        .smp_valid_i(smp_valid), .smp_ready_o(smp_ready), .casc_i(casc),
        .res_data_o(res_data), .res_valid_o(res_valid),
        .res_ready_i(res_ready));
    ctf_peer u_ctf_peer (.clock_i(clock_i), .reset_i(reset_i),
        .take_i(smp_valid && smp_ready), .hold_i(hold), .casc_o(casc),
        .ready_o(res_ready));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    // Coefficient cut to the selected width and sign-extended
    function automatic longint sx(logic [15:0] c);
        int n;
        logic signed [15:0] t;
        n = 4 * (int'(cwm) + 1);
        t = c << (16 - n);
        return longint'(t >>> (16 - n));
    endfunction
    // Transposed chain: each sample meets every tap of the live bank
    function automatic logic [23:0] model(logic [15:0] x, logic [23:0] c);
        longint xs, y;
        int l;
        l = (shm == 2'h0) ? SH_LSB0 : (shm == 2'h1) ? SH_LSB1
          : (shm == 2'h2) ? SH_LSB2 : SH_LSB3;
        xs = longint'($signed(x));
        y = ch[1] + sx(coef[mb][0]) * xs;
        for (int k = 1; k < 32; k++) ch[k] = ch[k + 1] + sx(coef[mb][k]) * xs;
        y = (y + (longint'(1) << (l - 1))) >>> l;
        cq.push_back(c);
        model = y[23:0] + cq.pop_front();
        if (cont) mb = ~mb;
    endfunction

    ////////////////////////////////////////////////////////////////////
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One host cycle; the next call or idle replaces the strobes
    task automatic acc(logic w, logic r, logic [7:0] a, logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge clock_i);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        rq.push_back(e);
        acc(1'b0, 1'b1, a, '0);
    endtask
    task automatic idle();
        bus <= '0;
        @(posedge clock_i);
    endtask
    task automatic setc(logic sw, ct, logic [1:0] cw, sh, logic mio);
        acc(1'b1, 1'b0, REG_CTRL, {25'h0, mio, sh, cw, ct, sw});
        mb ^= sw;
        cont = ct;
        cwm = cw;
        shm = sh;
    endtask
    // Offer a sample and hold it until the filter takes it
    task automatic put(logic [15:0] x);
        int n;
        n = 0;
        smp_data <= x;
        smp_valid <= 1'b1;
        do begin
            @(negedge clock_i);
            n++;
        end while (smp_ready !== 1'b1 && n < 60);
        xq.push_back(model(x, casc));
        @(posedge clock_i);
    endtask
    task automatic drain();
        smp_valid <= 1'b0;
        for (int i = 0; i < 300 && xq.size() > 0; i++) @(posedge clock_i);
    endtask

    // Compare read answers and drained results with the oldest notes
    always @(negedge clock_i) begin
        if (rd_prev) chk(rd_data, rq.pop_front());
        rd_prev = bus.rd;
        if (res_valid && res_ready)
            chk({8'h0, res_data}, xq.pop_front());
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        for (int k = 0; k < 33; k++) ch[k] = 0;
        for (int k = 0; k < 31; k++) cq.push_back(24'h000000);
        for (int k = 0; k < 32; k++) coef[0][k] = '0;
        repeat (12) @(posedge clock_i);
        reset_i <= 1'b0;
        rd(REG_CTRL, 32'h0000000C);
        rd(REG_STAT, 32'h00000008);
        rd(8'h10, 32'h00000000);
        for (int k = 0; k < 32; k++) begin
            rng = lfsr(rng);
            coef[1][k] = rng[15:0];
            acc(1'b1, 1'b0, REG_COEF + 8'(k), {16'h0, rng[15:0]});
        end
        rd(REG_COEF + 8'h05, {16'h0, coef[1][5]});
        setc(1'b1, 1'b0, 2'h3, 2'h0, 1'b0);
        rd(REG_STAT, 32'h00000009);
        idle();
        // Every width and window position, samples back to back
        for (int w = 0; w < 4; w++) begin
            setc(1'b0, 1'b0, 2'(w), 2'(w), 1'b0);
            idle();
            for (int n = 0; n < 10; n++) begin
                rng = lfsr(rng);
                put(rng[15:0]);
            end
            drain();
        end
        // Buffer full with the drain stalled: third sample must wait
        hold <= 1'b1;
        put(16'h7FFF);
        put(16'h8000);
        smp_data <= 16'h1234;
        repeat (20) @(posedge clock_i);
        @(negedge clock_i);
        chk({31'h0, smp_ready}, 32'h00000000);
        @(posedge clock_i);
        hold <= 1'b0;
        put(16'h1234);
        drain();
        // Banks alternate by themselves in continuous mode
        setc(1'b0, 1'b1, 2'h0, 2'h1, 1'b0);
        idle();
        for (int n = 0; n < 7; n++) put(16'(n * 977));
        drain();
        setc(1'b0, 1'b0, 2'h3, 2'h2, 1'b0);
        rd(REG_STAT, {28'h0, 3'b100, mb});
        // Sample in and result out through the host port
        setc(1'b0, 1'b0, 2'h3, 2'h2, 1'b1);
        acc(1'b1, 1'b0, REG_DIN, 32'h0000ABCD);
        idle();
        repeat (10) @(posedge clock_i);
        rd(REG_DOUT, {8'h0, model(16'hABCD, casc)});
        idle();
        idle();
        end_of_test();
    end
endmodule // ctf_filter_test
